//--- src/fpse_defines.vh
/*
   fpse_defines.vh: register offsets, field positions, reset values and
   operation kinds for the flash program setup and fault block.
   Assumes inclusion by bare name from the design, checker and bench files.
*/
`ifndef FPSE_DEFINES_VH
`define FPSE_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte addresses on the plain register port
`define FPSE_ADDR_W               20
`define FPSE_OFF_DATA_B_LOW       20'h8000c
`define FPSE_OFF_DATA_B_HIGH      20'h8000e
`define FPSE_OFF_LOC_LOW          20'h80010
`define FPSE_OFF_LOC_HIGH         20'h80012
`define FPSE_OFF_FAULT_FLAGS      20'h80014
`define FPSE_OFF_IRQ_STATUS       20'h80016
`define FPSE_OFF_IRQ_MASK         20'h80018
`define FPSE_OFF_SECT_FUSE        20'h8001a
`define FPSE_OFF_ACC_FUSE_ZERO    20'h8001c
`define FPSE_OFF_ACC_FUSE_ONE_LO  20'h8001e
`define FPSE_OFF_ACC_FUSE_ONE_HI  20'h80020

////////////////////////////////////////////////////////////////////////////////
// reset values
`define FPSE_RST_DATA             16'hffff
`define FPSE_RST_LOC              16'h0000
`define FPSE_RST_ZERO             16'h0000

////////////////////////////////////////////////////////////////////////////////
// fault flag bit positions
`define FPSE_F_WRITE_ERR          0
`define FPSE_F_ERASE_CELL         1
`define FPSE_F_PROGRAM_CELL       2
`define FPSE_F_ONE_OVER_ZERO      3
`define FPSE_F_SETUP_ORDER        4
`define FPSE_F_RESUME             5
`define FPSE_F_PROT_HIT           6
`define FPSE_NFLAGS               7

// interrupt status bit positions
`define FPSE_I_FAULT              0
`define FPSE_I_FUSES_LOADED       1
`define FPSE_I_WRITE_LAUNCH       2
`define FPSE_NIRQ                 3

////////////////////////////////////////////////////////////////////////////////
// operation kinds on op_kind_in
`define FPSE_OP_WORD              2'h0
`define FPSE_OP_DWORD             2'h1
`define FPSE_OP_SET_PROT          2'h2
`define FPSE_OP_ERASE             2'h3

// fields
`define FPSE_LOC_LOW_MASK         16'hfffc
`define FPSE_LOC_HIGH_W           5
`define FPSE_SECT_LSB             13
`define FPSE_LAST_SECTOR          4'h9

`endif

//--- src/fpse_top.v
/*
   fpse_top.v: program data and target location registers, sticky write
   fault flags, fuse copy at reset and protection gating of write starts.
   Assumes a write engine that raises bank_zero_busy_in while it works and
   reports cell failures as one-cycle pulses, and a fuse array that answers
   a read request with a valid pulse.
*/
// Decided for this implementation: strobed register access.
// Overview of operation
// - location low holds address 15:2, two low bits reserved and zero
// - location high supplies address bits 20:16 for programming
// - register reads are not valid while the controller lock is high
// - fault flags are set only while bank zero busy is low
// - write error flag is set by any fault, sticky until cleared
// - erase cell failure sets a sticky flag
// - program cell failure sets a sticky flag
// - programming a zero bit to one sets a sticky flag, except set-protection
// - inconsistent setup sets a sticky flag and no write is started
// - resume protocol error aborts suspended work and sets a sticky flag
// - hits on protected sectors set a flag; unprotected erase sectors proceed
// - fuse words are read once after reset into four volatile copies
// - every protection is held active until the fuses have been read
// - set-protection is refused while code is fetched from the flash
// - four one-time fuse words: one sector write word, three access words
// - a sector write fuse at zero blocks writes to that sector
`timescale 1ns/1ns
`include "fpse_defines.vh"

module fpse_top #(
   parameter NSECT = 10
) (
   // clock and reset
   input  wire                      core_clk_in,
   input  wire                      rst_b_in,
   // register port
   input  wire [`FPSE_ADDR_W-1:0]   reg_addr_in,
   input  wire [15:0]               reg_wdata_in,
   input  wire                      reg_wr_in,
   input  wire                      reg_rd_in,
   output reg  [15:0]               reg_rdata_out,
   // controller status and start
   input  wire                      lock_in,
   input  wire                      bank_zero_busy_in,
   input  wire                      op_start_in,
   input  wire [1:0]                op_kind_in,
   input  wire [NSECT-1:0]          erase_select_in,
   input  wire                      fetch_from_flash_in,
   input  wire [31:0]               old_cells_in,
   // engine fault reports
   input  wire                      erase_cell_fail_in,
   input  wire                      program_cell_fail_in,
   input  wire                      resume_protocol_err_in,
   // fuse array
   output reg                       fuse_read_req_out,
   input  wire                      fuse_valid_in,
   input  wire [15:0]               fuse_sect_in,
   input  wire [15:0]               fuse_acc_zero_in,
   input  wire [15:0]               fuse_acc_one_low_in,
   input  wire [15:0]               fuse_acc_one_high_in,
   // to write engine
   output reg                       write_go_out,
   output reg  [1:0]                write_kind_out,
   output reg  [20:0]               write_addr_out,
   output reg  [31:0]               write_data_out,
   output reg  [NSECT-1:0]          erase_allow_out,
   output reg                       resume_abort_out,
   // protection state
   output reg  [NSECT-1:0]          sector_write_fuse_bits_out,
   output reg                       access_protect_out,
   // interrupt
   output reg                       irq_out
);

   localparam ST_LOAD = 2'b01;
   localparam ST_RUN  = 2'b10;

   function hit;
      input [`FPSE_ADDR_W-1:0] a;
      input [`FPSE_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   function [3:0] sector_of;
      input [20:0] a;
      reg   [7:0]  s;
      begin
         s = a[20:`FPSE_SECT_LSB];
         if (s > {4'h0, `FPSE_LAST_SECTOR}) begin
            sector_of = `FPSE_LAST_SECTOR;
         end else begin
            sector_of = s[3:0];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   reg  [15:0]               data_b_low;
   reg  [15:0]               data_b_high;
   reg  [15:0]               loc_low;
   reg  [`FPSE_LOC_HIGH_W-1:0] loc_high;
   reg  [`FPSE_NFLAGS-1:0]   fault_flags;
   reg  [`FPSE_NFLAGS-1:0]   pend;
   reg  [`FPSE_NIRQ-1:0]     irq_status;
   reg  [`FPSE_NIRQ-1:0]     irq_mask;
   reg  [15:0]               sect_fuse;
   reg  [15:0]               acc_fuse_zero;
   reg  [15:0]               acc_fuse_one_low;
   reg  [15:0]               acc_fuse_one_high;
   reg  [1:0]                state;

   wire                      loaded;
   wire [20:0]               target;
   wire [NSECT-1:0]          wp_eff;
   wire [3:0]                tsect;

   assign loaded = (state == ST_RUN);
   assign target = {loc_high, loc_low[15:2], 2'b00};
   assign tsect  = sector_of(target);

   // all sectors read as protected before load
   genvar g;
   generate
      for (g = 0; g < NSECT; g = g + 1) begin : g_wp
         assign wp_eff[g] = loaded & sect_fuse[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // start checks
   reg  [`FPSE_NFLAGS-1:0]   start_ev;
   reg                       start_ok;
   reg  [NSECT-1:0]          erase_ok;

   always @* begin
      start_ev = {`FPSE_NFLAGS{1'b0}};
      start_ok = 1'b0;
      erase_ok = erase_select_in & wp_eff;
      if (op_start_in) begin
         start_ok = 1'b1;
         case (op_kind_in)
            `FPSE_OP_DWORD: begin
               // misaligned double-word is a setup fault
               if (loc_low[2]) begin
                  start_ev[`FPSE_F_SETUP_ORDER] = 1'b1;
                  start_ok = 1'b0;
               end
            end
            `FPSE_OP_SET_PROT: begin
               if (fetch_from_flash_in) begin
                  start_ev[`FPSE_F_SETUP_ORDER] = 1'b1;
                  start_ok = 1'b0;
               end
            end
            `FPSE_OP_ERASE: begin
               if (erase_select_in == {NSECT{1'b0}}) begin
                  start_ev[`FPSE_F_SETUP_ORDER] = 1'b1;
                  start_ok = 1'b0;
               end
               // protected sectors skipped, rest still erased
               if ((erase_select_in & ~wp_eff) != {NSECT{1'b0}}) begin
                  start_ev[`FPSE_F_PROT_HIT] = 1'b1;
                  if (erase_ok == {NSECT{1'b0}}) begin
                     start_ok = 1'b0;
                  end
               end
            end
            default: begin
            end
         endcase
         // a new start while the engine works breaks the sequence
         if (bank_zero_busy_in || lock_in) begin
            start_ev[`FPSE_F_SETUP_ORDER] = 1'b1;
            start_ok = 1'b0;
         end
         if (op_kind_in == `FPSE_OP_WORD || op_kind_in == `FPSE_OP_DWORD) begin
            if (!wp_eff[tsect]) begin
               start_ev[`FPSE_F_PROT_HIT] = 1'b1;
               start_ok = 1'b0;
            end
            // a one over a stored zero is flagged, the write still starts
            if ((~old_cells_in & {data_b_high, data_b_low}) != 32'h0000_0000) begin
               start_ev[`FPSE_F_ONE_OVER_ZERO] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fault collection and commit
   reg  [`FPSE_NFLAGS-1:0]   new_ev;
   reg  [`FPSE_NFLAGS-1:0]   next_pend;
   reg  [`FPSE_NFLAGS-1:0]   commit;
   reg  [`FPSE_NFLAGS-1:0]   next_fault_flags;
   reg                       flag_wr;

   always @* begin
      new_ev = start_ev;
      new_ev[`FPSE_F_ERASE_CELL]   = erase_cell_fail_in;
      new_ev[`FPSE_F_PROGRAM_CELL] = program_cell_fail_in;
      new_ev[`FPSE_F_RESUME]       = resume_protocol_err_in;
      // any fault raises the write error
      new_ev[`FPSE_F_WRITE_ERR]    = (new_ev != {`FPSE_NFLAGS{1'b0}});
      // flags set only when bank zero is idle
      commit    = bank_zero_busy_in ? {`FPSE_NFLAGS{1'b0}} : pend;
      next_pend = (pend & ~commit) | new_ev;
      flag_wr   = reg_wr_in & hit(reg_addr_in, `FPSE_OFF_FAULT_FLAGS);
      next_fault_flags = fault_flags;
      if (flag_wr) begin
         next_fault_flags = fault_flags & reg_wdata_in[`FPSE_NFLAGS-1:0];
      end
      next_fault_flags = next_fault_flags | commit;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // fuse load state machine
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state             <= ST_LOAD;
         fuse_read_req_out <= 1'b0;
         sect_fuse         <= `FPSE_RST_ZERO;
         acc_fuse_zero     <= `FPSE_RST_ZERO;
         acc_fuse_one_low  <= `FPSE_RST_ZERO;
         acc_fuse_one_high <= `FPSE_RST_ZERO;
      end else begin
         case (state)
            ST_LOAD: begin
               // one sector word, three access words
               fuse_read_req_out <= ~fuse_valid_in;
               if (fuse_valid_in) begin
                  sect_fuse         <= fuse_sect_in;
                  acc_fuse_zero     <= fuse_acc_zero_in;
                  acc_fuse_one_low  <= fuse_acc_one_low_in;
                  acc_fuse_one_high <= fuse_acc_one_high_in;
                  state             <= ST_RUN;
               end
            end
            ST_RUN: begin
               fuse_read_req_out <= 1'b0;
            end
            default: begin
               state             <= ST_LOAD;
               fuse_read_req_out <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // software registers and faults
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         data_b_low  <= `FPSE_RST_DATA;
         data_b_high <= `FPSE_RST_DATA;
         loc_low     <= `FPSE_RST_LOC;
         loc_high    <= {`FPSE_LOC_HIGH_W{1'b0}};
         irq_mask    <= {`FPSE_NIRQ{1'b0}};
         fault_flags <= {`FPSE_NFLAGS{1'b0}};
         pend        <= {`FPSE_NFLAGS{1'b0}};
      end else begin
         // data pair b written by software
         if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_DATA_B_LOW)) begin
            data_b_low <= reg_wdata_in;
         end
         if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_DATA_B_HIGH)) begin
            data_b_high <= reg_wdata_in;
         end
         if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_LOC_LOW)) begin
            loc_low <= reg_wdata_in & `FPSE_LOC_LOW_MASK;
         end
         if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_LOC_HIGH)) begin
            loc_high <= reg_wdata_in[`FPSE_LOC_HIGH_W-1:0];
         end
         if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_IRQ_MASK)) begin
            irq_mask <= reg_wdata_in[`FPSE_NIRQ-1:0];
         end
         fault_flags <= next_fault_flags;
         pend        <= next_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt status, write one to clear, set wins
   reg  [`FPSE_NIRQ-1:0]     irq_set;
   reg  [`FPSE_NIRQ-1:0]     next_irq_status;

   always @* begin
      irq_set = {`FPSE_NIRQ{1'b0}};
      irq_set[`FPSE_I_FAULT]        = (commit != {`FPSE_NFLAGS{1'b0}});
      irq_set[`FPSE_I_FUSES_LOADED] = (state == ST_LOAD) & fuse_valid_in;
      irq_set[`FPSE_I_WRITE_LAUNCH] = start_ok;
      next_irq_status = irq_status;
      if (reg_wr_in && hit(reg_addr_in, `FPSE_OFF_IRQ_STATUS)) begin
         next_irq_status = irq_status & ~reg_wdata_in[`FPSE_NIRQ-1:0];
      end
      next_irq_status = next_irq_status | irq_set;
   end

   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_status <= {`FPSE_NIRQ{1'b0}};
         irq_out    <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_out    <= (next_irq_status & irq_mask) != {`FPSE_NIRQ{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write engine launch and protection outputs
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         write_go_out               <= 1'b0;
         write_kind_out             <= `FPSE_OP_WORD;
         write_addr_out             <= 21'h000000;
         write_data_out             <= 32'hffffffff;
         erase_allow_out            <= {NSECT{1'b0}};
         resume_abort_out           <= 1'b0;
         sector_write_fuse_bits_out <= {NSECT{1'b0}};
         access_protect_out         <= 1'b1;
      end else begin
         // nothing launched on a bad setup
         write_go_out     <= start_ok;
         if (start_ok) begin
            write_kind_out  <= op_kind_in;
            write_addr_out  <= target;
            write_data_out  <= {data_b_high, data_b_low};
            erase_allow_out <= (op_kind_in == `FPSE_OP_ERASE) ? erase_ok : {NSECT{1'b0}};
         end
         resume_abort_out <= resume_protocol_err_in;
         sector_write_fuse_bits_out <= wp_eff;
         access_protect_out         <= ~loaded | ~acc_fuse_zero[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe
   reg  [15:0]               rmux;

   always @* begin
      rmux = 16'h0000;
      if (hit(reg_addr_in, `FPSE_OFF_DATA_B_LOW)) begin
         rmux = data_b_low;
      end else if (hit(reg_addr_in, `FPSE_OFF_DATA_B_HIGH)) begin
         rmux = data_b_high;
      end else if (hit(reg_addr_in, `FPSE_OFF_LOC_LOW)) begin
         rmux = loc_low;
      end else if (hit(reg_addr_in, `FPSE_OFF_LOC_HIGH)) begin
         rmux = {11'h000, loc_high};
      end else if (hit(reg_addr_in, `FPSE_OFF_FAULT_FLAGS)) begin
         rmux = {9'h000, fault_flags};
      end else if (hit(reg_addr_in, `FPSE_OFF_IRQ_STATUS)) begin
         rmux = {13'h0000, irq_status};
      end else if (hit(reg_addr_in, `FPSE_OFF_IRQ_MASK)) begin
         rmux = {13'h0000, irq_mask};
      end else if (hit(reg_addr_in, `FPSE_OFF_SECT_FUSE)) begin
         rmux = sect_fuse;
      end else if (hit(reg_addr_in, `FPSE_OFF_ACC_FUSE_ZERO)) begin
         rmux = acc_fuse_zero;
      end else if (hit(reg_addr_in, `FPSE_OFF_ACC_FUSE_ONE_LO)) begin
         rmux = acc_fuse_one_low;
      end else if (hit(reg_addr_in, `FPSE_OFF_ACC_FUSE_ONE_HI)) begin
         rmux = acc_fuse_one_high;
      end
   end

   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in && !lock_in) begin
         reg_rdata_out <= rmux;
      end else begin
         // locked reads return zero; data stands one cycle
         reg_rdata_out <= 16'h0000;
      end
   end

endmodule // fpse_top

//--- verification/fpse_checker_props.sv
/* fpse_checker_props.sv: port checker for the flash program setup block.
   Assumes it is bound to every fpse_top instance. */
`timescale 1ns/1ns
`include "fpse_defines.vh"
module fpse_checker #(
   parameter NSECT = 10
) (
   // clock and reset
   input wire             core_clk_in,
   input wire             rst_b_in,
   // register port and status
   input wire             reg_rd_in,
   input wire             lock_in,
   input wire [15:0]      reg_rdata_out,
   input wire             bank_zero_busy_in,
   // starts
   input wire             op_start_in,
   input wire [1:0]       op_kind_in,
   input wire             fetch_from_flash_in,
   input wire             resume_protocol_err_in,
   // outputs watched
   input wire             resume_abort_out,
   input wire             fuse_read_req_out,
   input wire [NSECT-1:0] sector_write_fuse_bits_out,
   input wire             access_protect_out,
   input wire             write_go_out,
   input wire [1:0]       write_kind_out,
   input wire [20:0]      write_addr_out,
   input wire [NSECT-1:0] erase_allow_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////
   AST_LOCK_READ: assert property (reg_rd_in && lock_in |=> reg_rdata_out == 16'h0000)
      else $error("read under lock returned data");
   AST_FUSE_HELD: assert property (fuse_read_req_out |-> access_protect_out
      && sector_write_fuse_bits_out == '0) else $error("protection open before fuse load");
   AST_GO_CAUSE: assert property (write_go_out |-> $past(op_start_in))
      else $error("launch without a start");
   AST_BUSY_REFUSE: assert property (op_start_in && (bank_zero_busy_in || lock_in)
      |=> !write_go_out) else $error("launch while busy or locked");
   AST_FETCH_REFUSE: assert property (op_start_in && fetch_from_flash_in
      && op_kind_in == `FPSE_OP_SET_PROT |=> !write_go_out) else $error("set-prot from flash");
   AST_DWORD_ALIGN: assert property (write_go_out && write_kind_out == `FPSE_OP_DWORD
      |-> !write_addr_out[2]) else $error("unaligned double word launched");
   AST_ADDR_LOW: assert property (write_go_out |-> write_addr_out[1:0] == 2'h0)
      else $error("launch address low bits set");
   AST_RESUME_ABORT: assert property (resume_protocol_err_in |=> resume_abort_out)
      else $error("resume error not aborted");
   AST_ERASE_PROT: assert property (write_go_out && write_kind_out == `FPSE_OP_ERASE
      |-> (erase_allow_out & ~sector_write_fuse_bits_out) == '0)
      else $error("protected sector allowed for erase");
   COV_GO: cover property (write_go_out);
   COV_ERASE: cover property (write_go_out && write_kind_out == `FPSE_OP_ERASE);
   COV_ABORT: cover property (resume_abort_out);
endmodule // fpse_checker

bind fpse_top fpse_checker #(.NSECT(NSECT)) i_fpse_checker (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_rd_in(reg_rd_in),
   .lock_in(lock_in), .reg_rdata_out(reg_rdata_out), .bank_zero_busy_in(bank_zero_busy_in),
   .op_start_in(op_start_in), .op_kind_in(op_kind_in),
   .fetch_from_flash_in(fetch_from_flash_in), .resume_protocol_err_in(resume_protocol_err_in),
   .resume_abort_out(resume_abort_out), .fuse_read_req_out(fuse_read_req_out),
   .sector_write_fuse_bits_out(sector_write_fuse_bits_out),
   .access_protect_out(access_protect_out), .write_go_out(write_go_out),
   .write_kind_out(write_kind_out), .write_addr_out(write_addr_out),
   .erase_allow_out(erase_allow_out)
);

//--- verification/fpse_top_tb_top.sv
/* fpse_top_tb_top.sv: directed bench for the flash program setup block.
   Assumes the bench plays the write engine, controller and fuse array. */
`timescale 1ns/1ns
`include "fpse_defines.vh"
module fpse_top_tb_top;
   logic        core_clk_in = 1'h0;
   logic        rst_b_in = 1'h0;
   logic [19:0] reg_addr_in = 20'h00000;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        reg_wr_in = 1'h0, reg_rd_in = 1'h0, lock_in = 1'h0, busy = 1'h0;
   logic        op_start_in = 1'h0, fetch_from_flash_in = 1'h0, fuse_valid_in = 1'h0;
   logic [1:0]  op_kind_in = 2'h0;
   logic [9:0]  erase_select_in = 10'h000;
   logic [31:0] old_cells_in = 32'hffffffff;
   logic [2:0]  ev = 3'h0;
   logic [15:0] fuse_sect_in = 16'hfdff;
   wire  [15:0] reg_rdata_out;
   wire         fuse_read_req_out, write_go_out, resume_abort_out, access_protect_out, irq_out;
   wire  [1:0]  write_kind_out;
   wire  [20:0] write_addr_out;
   wire  [31:0] write_data_out;
   wire  [9:0]  erase_allow_out, sector_write_fuse_bits_out;
   int          failures = 0, checks_done = 0;

   always #2 core_clk_in = ~core_clk_in;

   fpse_top #(.NSECT(10)) i_fpse_top (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .lock_in(lock_in), .bank_zero_busy_in(busy),
      .op_start_in(op_start_in), .op_kind_in(op_kind_in), .erase_select_in(erase_select_in),
      .fetch_from_flash_in(fetch_from_flash_in), .old_cells_in(old_cells_in),
      .erase_cell_fail_in(ev[0]), .program_cell_fail_in(ev[1]),
      .resume_protocol_err_in(ev[2]), .fuse_read_req_out(fuse_read_req_out),
      .fuse_valid_in(fuse_valid_in), .fuse_sect_in(fuse_sect_in),
      .fuse_acc_zero_in(16'h00ff), .fuse_acc_one_low_in(16'h1234),
      .fuse_acc_one_high_in(16'h5678), .write_go_out(write_go_out),
      .write_kind_out(write_kind_out), .write_addr_out(write_addr_out),
      .write_data_out(write_data_out), .erase_allow_out(erase_allow_out),
      .resume_abort_out(resume_abort_out),
      .sector_write_fuse_bits_out(sector_write_fuse_bits_out),
      .access_protect_out(access_protect_out), .irq_out(irq_out)
   );
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'h1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'h0;
   endtask

   // data stands only in the cycle after the strobe
   task automatic rd(input logic [19:0] a, input logic [15:0] e, input string what);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'h1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'h0;
      #1 chk(what, {16'h0000, e}, {16'h0000, reg_rdata_out});
   endtask

   task automatic flt(input logic [15:0] e);
      rd(`FPSE_OFF_FAULT_FLAGS, e, "fault flags");
      wr(`FPSE_OFF_FAULT_FLAGS, 16'h0000);
   endtask

   task automatic st(input logic [1:0] k, input logic [9:0] sel, input logic [31:0] old,
                     input logic go);
      @(posedge core_clk_in);
      op_kind_in <= k;
      erase_select_in <= sel;
      old_cells_in <= old;
      op_start_in <= 1'h1;
      @(posedge core_clk_in);
      op_start_in <= 1'h0;
      #1 chk("launch", {31'h0, go}, {31'h0, write_go_out});
   endtask

   task automatic pulse(input logic [2:0] which);
      @(posedge core_clk_in);
      ev <= which;
      @(posedge core_clk_in);
      ev <= 3'h0;
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // bound far above the roughly 165 cycles the tests need
   initial begin
      #40000;
      failures++;
      finish_test;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge core_clk_in);
      rst_b_in <= 1'h1;
      for (int i = 0; i < 20 && fuse_read_req_out !== 1'h1; i++) @(posedge core_clk_in);
      #1 chk("bits before load", 32'h0, {22'h0, sector_write_fuse_bits_out});
      chk("access before load", 32'h1, {31'h0, access_protect_out});
      chk("fuse request", 32'h1, {31'h0, fuse_read_req_out});
      @(posedge core_clk_in);
      fuse_valid_in <= 1'h1;
      @(posedge core_clk_in);
      fuse_valid_in <= 1'h0;
      fuse_sect_in <= 16'h0000;
      repeat (2) @(posedge core_clk_in);
      fuse_valid_in <= 1'h1;
      @(posedge core_clk_in);
      fuse_valid_in <= 1'h0;
      repeat (2) @(posedge core_clk_in);
      #1 chk("fuse bits", 32'h1ff, {22'h0, sector_write_fuse_bits_out});
      chk("access", 32'h0, {31'h0, access_protect_out});
      rd(20'h8001a, 16'hfdff, "sector fuse copy");
      wr(20'h8001a, 16'h0000);
      rd(20'h8001a, 16'hfdff, "sector fuse kept");
      rd(20'h8001c, 16'h00ff, "access fuse zero");
      rd(20'h8001e, 16'h1234, "access fuse one low");
      rd(20'h80020, 16'h5678, "access fuse one high");
      $display("test fuses done");
      rd(20'h8000e, 16'hffff, "data b high reset");
      rd(20'h80010, 16'h0000, "location low reset");
      rd(20'h80030, 16'h0000, "unmapped");
      wr(20'h80010, 16'hffff);
      rd(20'h80010, 16'hfffc, "location low mask");
      lock_in <= 1'h1;
      rd(20'h8000e, 16'h0000, "locked read");
      lock_in <= 1'h0;
      $display("test registers done");
      wr(20'h8000c, 16'h5678);
      wr(20'h8000e, 16'h1234);
      wr(20'h80012, 16'h0001);
      wr(20'h80010, 16'h0004);
      st(`FPSE_OP_WORD, 10'h000, 32'hffffffff, 1'h1);
      chk("word address", 32'h10004, {11'h0, write_addr_out});
      chk("word data", 32'h12345678, write_data_out);
      flt(16'h0000);
      st(`FPSE_OP_WORD, 10'h000, 32'h00000000, 1'h1);
      flt(16'h0009);
      st(`FPSE_OP_SET_PROT, 10'h000, 32'h00000000, 1'h1);
      flt(16'h0000);
      fetch_from_flash_in <= 1'h1;
      st(`FPSE_OP_SET_PROT, 10'h000, 32'hffffffff, 1'h0);
      fetch_from_flash_in <= 1'h0;
      flt(16'h0011);
      st(`FPSE_OP_DWORD, 10'h000, 32'hffffffff, 1'h0);
      flt(16'h0011);
      wr(20'h80010, 16'h0008);
      st(`FPSE_OP_DWORD, 10'h000, 32'hffffffff, 1'h1);
      chk("dword address", 32'h10008, {11'h0, write_addr_out});
      chk("dword kind", 32'h1, {30'h0, write_kind_out});
      busy <= 1'h1;
      st(`FPSE_OP_WORD, 10'h000, 32'hffffffff, 1'h0);
      busy <= 1'h0;
      flt(16'h0011);
      wr(20'h80010, 16'h2000);
      st(`FPSE_OP_WORD, 10'h000, 32'hffffffff, 1'h0);
      flt(16'h0041);
      st(`FPSE_OP_ERASE, 10'h201, 32'hffffffff, 1'h1);
      chk("erase allow", 32'h001, {22'h0, erase_allow_out});
      flt(16'h0041);
      st(`FPSE_OP_ERASE, 10'h200, 32'hffffffff, 1'h0);
      flt(16'h0041);
      st(`FPSE_OP_ERASE, 10'h000, 32'hffffffff, 1'h0);
      flt(16'h0011);
      $display("test launches done");
      busy <= 1'h1;
      pulse(3'h1);
      rd(`FPSE_OFF_FAULT_FLAGS, 16'h0000, "held while busy");
      busy <= 1'h0;
      wr(`FPSE_OFF_FAULT_FLAGS, 16'hffff);
      rd(`FPSE_OFF_FAULT_FLAGS, 16'h0003, "sticky on ones");
      flt(16'h0003);
      pulse(3'h2);
      flt(16'h0005);
      pulse(3'h4);
      #1 chk("resume abort", 32'h1, {31'h0, resume_abort_out});
      flt(16'h0021);
      $display("test faults done");
      wr(`FPSE_OFF_IRQ_STATUS, 16'hffff);
      wr(`FPSE_OFF_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge core_clk_in);
      #1 chk("irq idle", 32'h0, {31'h0, irq_out});
      pulse(3'h2);
      rd(`FPSE_OFF_IRQ_STATUS, 16'h0001, "irq status");
      chk("irq raised", 32'h1, {31'h0, irq_out});
      wr(`FPSE_OFF_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge core_clk_in);
      #1 chk("irq masked", 32'h0, {31'h0, irq_out});
      wr(`FPSE_OFF_IRQ_MASK, 16'h0001);
      wr(`FPSE_OFF_IRQ_STATUS, 16'h0001);
      repeat (2) @(posedge core_clk_in);
      #1 chk("irq cleared", 32'h0, {31'h0, irq_out});
      $display("test interrupt done");
      finish_test;
   end
endmodule // fpse_top_tb_top
